// ===== rtl/msq_pkg.sv
// Constants and types shared by the microsequencer files
package msq_pkg;
  localparam int CLK_PERIOD_NS          = 5;
  localparam int FASTEST_STEP_PERIOD_NS = 105;
  localparam int SECOND_STEP_PERIOD_NS  = 125;
  localparam int THIRD_STEP_PERIOD_NS   = 145;
  localparam int SLOWEST_STEP_PERIOD_NS = 175;
  localparam int FASTEST_STEP_PERIOD =
    (FASTEST_STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SECOND_STEP_PERIOD =
    (SECOND_STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int THIRD_STEP_PERIOD =
    (THIRD_STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOWEST_STEP_PERIOD =
    (SLOWEST_STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_CNT_W = 6;

  localparam int CSA_W    = 14;
  localparam int NA_W     = 13;
  localparam int BANK_BIT = 13;
  localparam logic [CSA_W-1:0] CSA_RESET     = 14'h0000;
  localparam logic [9:0]       RET_MASK_HIGH = 10'h3FF;
  localparam logic             TOGGLE_RESET  = 1'b0;

  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [7:0]  REG_STACK0 = 8'h08;
  localparam logic [7:0]  REG_STACK1 = 8'h0C;
  localparam int          CTRL_RUN_BIT    = 0;
  localparam int          CTRL_STEP_BIT   = 1;
  localparam logic        CTRL_RUN_RESET  = 1'b1;
  localparam int          STATUS_TOP_BIT  = 16;
  localparam int          STATUS_SIGN_BIT = 17;
  localparam int          STATUS_ZERO_BIT = 18;
  localparam int          STATUS_RUN_BIT  = 19;

  typedef enum logic [2:0] {
    BR_TEST    = 3'h0,
    BR_RETURN  = 3'h1,
    ARITHMETIC_MULTIWAY   = 3'h2,
    FLAG_MULTIWAY   = 3'h3,
    BR_PROC    = 3'h4,
    BR_SCRATCH = 3'h5,
    OPERAND_MULTIWAY = 3'h6,
    DECODE_TABLE_MULTIWAY  = 3'h7
  } msq_branch_e;

  typedef enum logic [1:0] {
    ST_HALT = 2'b01,
    ST_RUN  = 2'b10
  } msq_state_e;
endpackage : msq_pkg

// ===== rtl/msq_step_timer.sv
// Step period counter: one step_end pulse per firmware step
`timescale 1ns/1ps
`default_nettype none
module msq_step_timer
  import msq_pkg::*;
#(
  parameter int CNT_W = STEP_CNT_W
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [1:0] speed,
  output logic            step_end
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] gap_reg;
  logic             seen_reg;

  if ((1 << CNT_W) <= SLOWEST_STEP_PERIOD) begin : g_chk
    $error("step counter too narrow");
  end

  always_comb begin
    case (speed)
      2'h0:    limit = CNT_W'(FASTEST_STEP_PERIOD);
      2'h1:    limit = CNT_W'(SECOND_STEP_PERIOD);
      2'h2:    limit = CNT_W'(THIRD_STEP_PERIOD);
      default: limit = CNT_W'(SLOWEST_STEP_PERIOD);
    endcase
  end

  assign step_end = run && (cnt_reg == limit - 1'b1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (!run || step_end) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Independent gap counter, watched only by the check below
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_reg  <= '0;
      seen_reg <= 1'b0;
    end else begin
      gap_reg  <= (step_end || !run) ? '0 : gap_reg + 1'b1;
      seen_reg <= run && (seen_reg || step_end);
    end
  end

  step_period_a: assert property (@(posedge clk) disable iff (rst)
    step_end && seen_reg |-> gap_reg == limit - 1'b1)
    else $error("step period differs from speed field");
endmodule : msq_step_timer
`default_nettype wire

// ===== rtl/msq_return_stack.sv
// Two-entry toggling return stack
`timescale 1ns/1ps
`default_nettype none
module msq_return_stack
  import msq_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [CSA_W-1:0] push_addr,
  output logic      [CSA_W-1:0] top,
  output logic      [CSA_W-1:0] entry0,
  output logic      [CSA_W-1:0] entry1,
  output logic                  top_sel
);
  logic [CSA_W-1:0] entry_reg [2];
  logic             sel_reg;

  // Push lands in the slot that is not the top
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      entry_reg[0] <= CSA_RESET;
      entry_reg[1] <= CSA_RESET;
    end else if (push) begin
      entry_reg[~sel_reg] <= push_addr;
    end
  end

  // Push with a successful return in one step cancels the toggle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_reg <= TOGGLE_RESET;
    end else begin
      sel_reg <= sel_reg ^ (push ^ pop);
    end
  end

  assign top     = entry_reg[sel_reg];
  assign entry0  = entry_reg[0];
  assign entry1  = entry_reg[1];
  assign top_sel = sel_reg;

  stack_toggle_a: assert property (@(posedge clk) disable iff (rst)
    (push ^ pop) |=> sel_reg != $past(sel_reg))
    else $error("toggle missed on push or return");
  toggle_hold_a: assert property (@(posedge clk) disable iff (rst)
    !(push ^ pop) |=> $stable(sel_reg))
    else $error("toggle flipped without cause");
  push_top_a: assert property (@(posedge clk) disable iff (rst)
    push && !pop |=> top == $past(push_addr))
    else $error("pushed address is not the new top");
endmodule : msq_return_stack
`default_nettype wire

// ===== rtl/msq_sequencer.sv
// Microprogram sequencer: picks each firmware step's successor
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module msq_sequencer
  import msq_pkg::*;
#(
  parameter int COND_N = 64
) (
  input  wire logic             MCLK,
  input  wire logic             RST,
  input  wire logic [5:0]       TEST_CONDITION_FIELD,
  input  wire logic             BRANCH_INVERT_FIELD,
  input  wire logic [NA_W-1:0]  NEXT_ADDRESS_FIELD,
  input  wire logic [3:0]       MASK_FIELD,
  input  wire logic [2:0]       BRANCH_FIELD,
  input  wire logic [1:0]       STEP_SPEED_FIELD,
  input  wire logic             PUSH_EN,
  input  wire logic [CSA_W-1:0] PUSH_ADDRESS,
  input  wire logic [COND_N-1:0] CONDITIONS,
  input  wire logic [23:0]      ALU_RESULT,
  input  wire logic             LOAD_INDICATORS,
  input  wire logic             LIVE_ALU_CARRY,
  input  wire logic             QUOTIENT_LOW_BIT,
  input  wire logic [3:0]       TEMP_FLAGS,
  input  wire logic [7:0]       PROCEDURE_BUS,
  input  wire logic [3:0]       FIRST_SCRATCH_ADDRESS_REGISTER,
  input  wire logic [3:0]       FOURTH_SCRATCH_ADDRESS_REGISTER,
  input  wire logic [3:0]       CYCLE_COUNT,
  input  wire logic [3:0]       DECODE_OFFSET,
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic [31:0]      REG_WDATA,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  output logic      [31:0]      REG_RDATA,
  output logic      [CSA_W-1:0] CONTROL_STORE_ADDRESS,
  output logic                  STEP_END,
  output logic      [2:0]       DECODE_TABLE_SELECT,
  output logic                  SIGN_INDICATOR,
  output logic                  ZERO_INDICATOR
);
  if (COND_N != 64) begin : g_chk
    $error("test-condition field addresses exactly 64 conditions");
  end

  msq_state_e       state_reg;
  msq_state_e       state_next;
  logic [CSA_W-1:0] csa_reg;
  logic [CSA_W-1:0] csa_next;
  logic             run_reg;
  logic             step_req_reg;
  logic             sign_reg;
  logic             zero_reg;
  logic [2:0]       decode_sel_reg;
  logic [31:0]      rdata_reg;
  logic             step_end;
  logic             cond_raw;
  logic             taken;
  logic             ret_ok;
  logic [CSA_W-1:0] stack_top;
  logic [CSA_W-1:0] stack0;
  logic [CSA_W-1:0] stack1;
  logic             top_sel;
  logic [CSA_W-1:0] ret_mask;
  logic [CSA_W-1:0] else_addr;
  logic [3:0]       mw_sel;
  logic [3:0]       mw_src;
  logic [3:0]       mw_low;
  msq_branch_e      br;

  assign br = msq_branch_e'(BRANCH_FIELD);

  // Condition zero is a constant false, so a goto is a test whose
  // bank comes from the invert bit alone.
  assign cond_raw = (TEST_CONDITION_FIELD == 6'h00) ? 1'b0
                  : CONDITIONS[TEST_CONDITION_FIELD];
  assign taken = cond_raw ^ BRANCH_INVERT_FIELD;

  // Else alternative flips the masked low bits of the if alternative
  assign else_addr = {1'b0, NEXT_ADDRESS_FIELD[NA_W-1:4],
                      NEXT_ADDRESS_FIELD[3:0] ^ MASK_FIELD};

  assign ret_mask = {RET_MASK_HIGH, MASK_FIELD};
  assign ret_ok   = step_end && (br == BR_RETURN) && taken;

  // Multiway sources and which low bits they drive
  always_comb begin
    mw_sel = 4'h0;
    mw_src = 4'h0;
    case (br)
      ARITHMETIC_MULTIWAY: begin
        mw_sel = {2'b11, MASK_FIELD[1:0]};
        mw_src = {sign_reg, zero_reg, LIVE_ALU_CARRY, QUOTIENT_LOW_BIT};
      end
      FLAG_MULTIWAY: begin
        mw_sel = MASK_FIELD;
        mw_src = TEMP_FLAGS;
      end
      BR_PROC: begin
        mw_sel = {1'b0, MASK_FIELD[2:0]};
        mw_src = {1'b0, PROCEDURE_BUS[3], PROCEDURE_BUS[1],
                  PROCEDURE_BUS[0]};
      end
      BR_SCRATCH: begin
        mw_sel = {2'b00, MASK_FIELD[1:0]};
        mw_src = {2'b00, FOURTH_SCRATCH_ADDRESS_REGISTER[3],
                  FOURTH_SCRATCH_ADDRESS_REGISTER[1]};
      end
      OPERAND_MULTIWAY: begin
        mw_sel = {1'b0, MASK_FIELD[2:0]};
        mw_src = {1'b0, FIRST_SCRATCH_ADDRESS_REGISTER[3:1]};
      end
      DECODE_TABLE_MULTIWAY: begin
        mw_sel = MASK_FIELD;
        mw_src = DECODE_OFFSET;
      end
      default: begin
        mw_sel = 4'h0;
        mw_src = 4'h0;
      end
    endcase
  end

  for (genvar i = 0; i < 4; i++) begin : g_low
    assign mw_low[i] = mw_sel[i] ? mw_src[i]
                     : NEXT_ADDRESS_FIELD[i];
  end

  // Successor selection
  always_comb begin
    csa_next = csa_reg;
    case (br)
      BR_TEST: begin
        csa_next = taken ? {1'b1, NEXT_ADDRESS_FIELD}
                 : else_addr;
      end
      BR_RETURN: begin
        csa_next = taken ? (stack_top & ret_mask)
                 : {1'b0, NEXT_ADDRESS_FIELD};
      end
      default: begin
        csa_next = taken
                 ? {1'b1, NEXT_ADDRESS_FIELD[NA_W-1:4], mw_low}
                 : {1'b0, NEXT_ADDRESS_FIELD};
      end
    endcase
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      csa_reg <= CSA_RESET;
    end else if (step_end) begin
      csa_reg <= csa_next;
    end
  end

  // Run control: free running, or single steps on request
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_HALT: begin
        if (run_reg || step_req_reg) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (step_end && !run_reg) begin
          state_next = ST_HALT;
        end
      end
      default: begin
        state_next = ST_HALT;
      end
    endcase
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_HALT;
    end else begin
      state_reg <= state_next;
    end
  end

  msq_step_timer u_timer (
    .clk      (MCLK),
    .rst      (RST),
    .run      (state_reg == ST_RUN),
    .speed    (STEP_SPEED_FIELD),
    .step_end (step_end)
  );

  msq_return_stack u_stack (
    .clk       (MCLK),
    .rst       (RST),
    .push      (step_end && PUSH_EN),
    .pop       (ret_ok),
    .push_addr (PUSH_ADDRESS),
    .top       (stack_top),
    .entry0    (stack0),
    .entry1    (stack1),
    .top_sel   (top_sel)
  );

  // Indicators only change on an explicit load
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sign_reg <= 1'b0;
      zero_reg <= 1'b0;
    end else if (LOAD_INDICATORS) begin
      sign_reg <= ALU_RESULT[23];
      zero_reg <= (ALU_RESULT == 24'h000000);
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      decode_sel_reg <= 3'h0;
    end else begin
      decode_sel_reg <= CYCLE_COUNT[2:0];
    end
  end

  // Control register; a step request set in the clearing cycle wins
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      run_reg <= CTRL_RUN_RESET;
    end else if (REG_WR && (REG_ADDR == REG_CTRL)) begin
      run_reg <= REG_WDATA[CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      step_req_reg <= 1'b0;
    end else if (REG_WR && (REG_ADDR == REG_CTRL)
                 && REG_WDATA[CTRL_STEP_BIT]) begin
      step_req_reg <= 1'b1;
    end else if (state_reg == ST_HALT) begin
      step_req_reg <= 1'b0;
    end
  end

  // Read data valid in the cycle after the read strobe only
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rdata_reg <= 32'h0000_0000;
    end else if (!REG_RD) begin
      rdata_reg <= 32'h0000_0000;
    end else if (REG_ADDR == REG_CTRL) begin
      rdata_reg <= {31'h0000_0000, run_reg};
    end else if (REG_ADDR == REG_STATUS) begin
      rdata_reg <= {12'h000, state_reg == ST_RUN, zero_reg, sign_reg,
                    top_sel, 2'b00, csa_reg};
    end else if (REG_ADDR == REG_STACK0) begin
      rdata_reg <= {18'h00000, stack0};
    end else if (REG_ADDR == REG_STACK1) begin
      rdata_reg <= {18'h00000, stack1};
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign REG_RDATA             = rdata_reg;
  assign CONTROL_STORE_ADDRESS = csa_reg;
  assign STEP_END              = step_end;
  assign DECODE_TABLE_SELECT   = decode_sel_reg;
  assign SIGN_INDICATOR        = sign_reg;
  assign ZERO_INDICATOR        = zero_reg;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  addr_hold_a: assert property (
    !step_end |=> $stable(csa_reg))
    else $error("address moved inside a step");
  test_bank_a: assert property (
    step_end && br == BR_TEST |=> csa_reg[BANK_BIT] == $past(taken))
    else $error("bank does not follow test result");
  invert_pol_a: assert property (
    step_end && br == BR_TEST && TEST_CONDITION_FIELD == 6'h00
    |=> csa_reg[BANK_BIT] == $past(BRANCH_INVERT_FIELD))
    else $error("invert bit did not set polarity");
  else_low_a: assert property (
    step_end && br == BR_TEST && !taken
    |=> csa_reg[3:0] == ($past(NEXT_ADDRESS_FIELD[3:0]) ^ $past(MASK_FIELD)))
    else $error("else low bits not flipped by mask");
  return_top_a: assert property (
    step_end && br == BR_RETURN && taken
    |=> csa_reg == ($past(stack_top) & {10'h3FF, $past(MASK_FIELD)}))
    else $error("return did not take masked top");
  arith_ind_a: assert property (
    step_end && br == ARITHMETIC_MULTIWAY && taken
    |=> csa_reg[3:2] == {$past(sign_reg), $past(zero_reg)})
    else $error("arithmetic branch ignores indicators");
  multi_upper_a: assert property (
    step_end && br != BR_TEST && br != BR_RETURN
    |=> csa_reg[12:4] == $past(NEXT_ADDRESS_FIELD[12:4]))
    else $error("multiway changed undriven bits");
  ind_load_a: assert property (
    LOAD_INDICATORS |=> zero_reg == ($past(ALU_RESULT) == 24'h000000)
    && sign_reg == $past(ALU_RESULT[23]))
    else $error("indicators not captured on load");
endmodule : msq_sequencer
`default_nettype wire

// ===== test/msq_store_model.sv
// Control-store word register and datapath sources facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module msq_store_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        step_end,
  input  wire logic [43:0] word_in,
  input  wire logic [95:0] src_in,
  output logic      [43:0] word_q,
  output logic      [95:0] src_q,
  output logic             load_q
);
  // The next word and its sources change only at a step boundary, as the real word register does
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_q <= '0;
      src_q  <= '0;
    end else if (step_end) begin
      word_q <= word_in;
      src_q  <= src_in;
    end
  end

  // Indicators load in the first cycle of a step, well before the branch samples them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_q <= 1'b0;
    end else begin
      load_q <= step_end;
    end
  end
endmodule : msq_store_model
`default_nettype wire

// ===== test/microsequencer_next_address_test.sv
// Self-checking bench for the microsequencer
`timescale 1ns/1ps
`default_nettype none
module microsequencer_next_address_test;
  import msq_pkg::*;
  typedef struct packed {
    logic [2:0]  br;
    logic [5:0]  tc;
    logic        bi;
    logic [12:0] na;
    logic [3:0]  mk;
    logic [1:0]  spd;
    logic        push;
    logic [13:0] pa;
    logic [7:0]  s;
    logic [23:0] alu;
    logic        c;
    logic [13:0] ex;
  } msq_row_s;
  localparam int NROW = 20;
  localparam int PER [4] = '{FASTEST_STEP_PERIOD, SECOND_STEP_PERIOD,
                             THIRD_STEP_PERIOD, SLOWEST_STEP_PERIOD};
  // Pushed addresses are if-bank and test alternatives share a sixteen-step block
  localparam msq_row_s ROWS [NROW] = '{
    '{3'h0, 6'h00, 1'h0, 13'h0ABC, 4'h0, 2'h0, 1'h0, 14'h0000, 8'h00, 24'h0, 1'h0, 14'h0ABC},
    '{3'h0, 6'h00, 1'h1, 13'h1234, 4'h0, 2'h1, 1'h0, 14'h0000, 8'h00, 24'h0, 1'h0, 14'h3234},
    '{3'h0, 6'h05, 1'h0, 13'h0340, 4'hF, 2'h2, 1'h0, 14'h0000, 8'h00, 24'h0, 1'h1, 14'h2340},
    '{3'h0, 6'h05, 1'h0, 13'h0340, 4'hF, 2'h3, 1'h0, 14'h0000, 8'h00, 24'h0, 1'h0, 14'h034F},
    '{3'h0, 6'h3F, 1'h1, 13'h1FF5, 4'h5, 2'h0, 1'h1, 14'h2AB7, 8'h00, 24'h0, 1'h0, 14'h3FF5},
    '{3'h0, 6'h3F, 1'h1, 13'h1FF5, 4'h5, 2'h0, 1'h1, 14'h3456, 8'h00, 24'h0, 1'h1, 14'h1FF0},
    '{3'h1, 6'h00, 1'h1, 13'h0000, 4'hF, 2'h0, 1'h0, 14'h0000, 8'h00, 24'h0, 1'h0, 14'h3456},
    '{3'h1, 6'h00, 1'h1, 13'h0000, 4'h9, 2'h0, 1'h0, 14'h0000, 8'h00, 24'h0, 1'h0, 14'h2AB1},
    '{3'h1, 6'h07, 1'h0, 13'h0123, 4'hF, 2'h0, 1'h0, 14'h0000, 8'h00, 24'h0, 1'h0, 14'h0123},
    '{3'h1, 6'h07, 1'h0, 13'h0123, 4'hF, 2'h0, 1'h0, 14'h0000, 8'h00, 24'h0, 1'h1, 14'h3456},
    '{3'h1, 6'h00, 1'h1, 13'h0000, 4'hF, 2'h0, 1'h1, 14'h2111, 8'h00, 24'h0, 1'h0, 14'h2AB7},
    '{3'h2, 6'h00, 1'h1, 13'h1210, 4'h0, 2'h0, 1'h0, 14'h0000, 8'h00, 24'h800001, 1'h0, 14'h3218},
    '{3'h2, 6'h00, 1'h1, 13'h1210, 4'h3, 2'h0, 1'h0, 14'h0000, 8'h02, 24'h0, 1'h0, 14'h3216},
    '{3'h3, 6'h00, 1'h1, 13'h145F, 4'h6, 2'h0, 1'h0, 14'h0000, 8'h00, 24'h0, 1'h0, 14'h3459},
    '{3'h4, 6'h00, 1'h1, 13'h0AB0, 4'hD, 2'h0, 1'h0, 14'h0000, 8'h0B, 24'h0, 1'h0, 14'h2AB5},
    '{3'h5, 6'h00, 1'h1, 13'h1230, 4'h3, 2'h0, 1'h0, 14'h0000, 8'h08, 24'h0, 1'h0, 14'h3232},
    '{3'h6, 6'h00, 1'h1, 13'h1238, 4'h7, 2'h0, 1'h0, 14'h0000, 8'h0C, 24'h0, 1'h0, 14'h323E},
    '{3'h7, 6'h00, 1'h1, 13'h1000, 4'hF, 2'h0, 1'h0, 14'h0000, 8'h05, 24'h0, 1'h0, 14'h3005},
    '{3'h3, 6'h09, 1'h0, 13'h0777, 4'hF, 2'h0, 1'h0, 14'h0000, 8'h00, 24'h0, 1'h0, 14'h0777},
    '{3'h0, 6'h00, 1'h0, 13'h0000, 4'h0, 2'h0, 1'h0, 14'h0000, 8'h00, 24'h0, 1'h0, 14'h0000}};

  logic             mclk;
  logic             rst;
  logic [43:0]      word_in;
  logic [95:0]      src_in;
  logic [43:0]      wq;
  logic [95:0]      sq;
  logic             ld;
  logic [3:0]       cyc;
  logic [7:0]       reg_addr;
  logic [31:0]      reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  logic [31:0]      reg_rdata;
  logic [CSA_W-1:0] control_store_address;
  logic             step_end;
  logic [2:0]       dsel;
  logic             sgn;
  logic             zro;
  int               bad_count;
  int               n_compared;
  int               n;
  logic [31:0]      d;
  msq_row_s         r;

  msq_store_model msq_store_model_i (
    .clk(mclk), .rst(rst), .step_end(step_end), .word_in(word_in), .src_in(src_in),
    .word_q(wq), .src_q(sq), .load_q(ld));

  msq_sequencer msq_sequencer_i (
    .MCLK(mclk), .RST(rst), .TEST_CONDITION_FIELD(wq[5:0]), .BRANCH_INVERT_FIELD(wq[6]),
    .NEXT_ADDRESS_FIELD(wq[19:7]), .MASK_FIELD(wq[23:20]), .BRANCH_FIELD(wq[26:24]),
    .STEP_SPEED_FIELD(wq[28:27]), .PUSH_EN(wq[29]), .PUSH_ADDRESS(wq[43:30]),
    .CONDITIONS(sq[63:0]), .ALU_RESULT(sq[95:72]), .LOAD_INDICATORS(ld),
    .LIVE_ALU_CARRY(sq[65]), .QUOTIENT_LOW_BIT(sq[64]), .TEMP_FLAGS(sq[67:64]),
    .PROCEDURE_BUS(sq[71:64]), .FIRST_SCRATCH_ADDRESS_REGISTER(sq[67:64]),
    .FOURTH_SCRATCH_ADDRESS_REGISTER(sq[67:64]), .CYCLE_COUNT(cyc),
    .DECODE_OFFSET(sq[67:64]), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .CONTROL_STORE_ADDRESS(control_store_address), .STEP_END(step_end), .DECODE_TABLE_SELECT(dsel),
    .SIGN_INDICATOR(sgn), .ZERO_INDICATOR(zro));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : check

  // Counts cycles up to the next step pulse, returns just after the edge that ends the step
  task automatic wait_step(output int cnt);
    cnt = 0;
    do begin
      @(negedge mclk);
      cnt++;
    end while (step_end !== 1'b1 && cnt < 100);
    check("step pulse", {31'h0, step_end}, 32'h1);
    @(posedge mclk);
  endtask : wait_step

  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : reg_read

  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    end_of_test();
  end

  initial begin
    bad_count  = 0;
    n_compared = 0;
    rst        = 1'b1;
    word_in    = '0;
    src_in     = '0;
    cyc        = '0;
    reg_addr   = '0;
    reg_wdata  = '0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    #1 check("address after reset", 32'(control_store_address), 32'h0);
    for (int i = 0; i <= NROW; i++) begin
      if (i < NROW) begin
        r = ROWS[i];
        word_in <= {r.pa, r.push, r.spd, r.br, r.mk, r.na, r.bi, r.tc};
        src_in  <= {r.alu, r.s, r.c ? (64'h1 << r.tc) : ~(64'h1 << r.tc)};
      end
      wait_step(n);
      #1;
      if (i > 0) begin
        check("address", 32'(control_store_address), 32'(ROWS[i-1].ex));
        check("step length", 32'(n), 32'(PER[ROWS[i-1].spd]));
      end
    end
    check("zero indicator", {31'h0, zro}, 32'h1);
    check("sign indicator", {31'h0, sgn}, 32'h0);
    $display("table rows done");
    reg_read(REG_STACK0, d);
    check("stack entry 0", d, 32'h2111);
    reg_read(REG_STACK1, d);
    check("stack entry 1", d, 32'h2AB7);
    reg_read(REG_STATUS, d);
    check("stack toggle", {31'h0, d[STATUS_TOP_BIT]}, 32'h1);
    check("status word", d, 32'h000D_0000);
    reg_read(8'h10, d);
    check("unmapped read", d, 32'h0);
    @(posedge mclk);
    cyc <= 4'hD;
    repeat (2) @(posedge mclk);
    #1 check("decode table select", {29'h0, dsel}, 32'h5);
    $display("register and decode tests done");
    // Halted sequencer may finish the step in flight and then must stay put
    reg_write(REG_CTRL, 32'h0);
    n = 0;
    repeat (80) begin
      @(negedge mclk);
      if (step_end === 1'b1) n++;
    end
    check("steps while halted", 32'(n), 32'h1);
    reg_read(REG_STATUS, d);
    check("running flag halted", {31'h0, d[STATUS_RUN_BIT]}, 32'h0);
    // A single-step request runs exactly one step and halts again
    reg_write(REG_CTRL, 32'h2);
    n = 0;
    repeat (80) begin
      @(negedge mclk);
      if (step_end === 1'b1) n++;
    end
    check("single steps", 32'(n), 32'h1);
    reg_read(REG_CTRL, d);
    check("run bit readback", d, 32'h0);
    reg_write(REG_CTRL, 32'h1);
    wait_step(n);
    $display("run control test done");
    repeat (7) @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    #1 check("address after clear", 32'(control_store_address), 32'h0);
    reg_read(REG_STATUS, d);
    check("toggle after clear", {31'h0, d[STATUS_TOP_BIT]}, 32'h0);
    reg_read(REG_STACK1, d);
    check("stack after clear", d, 32'h0);
    $display("mid-run clear test done");
    end_of_test();
  end
endmodule : microsequencer_next_address_test
`default_nettype wire
